// ==== common/spp_pkg.sv ====
// Shared constants, field layouts and types of the potentiometer serial interface.
package spp_pkg;

    // Resistor string and register widths.
    localparam int SPP_SEGMENTS = 63;
    localparam int SPP_TAPS     = SPP_SEGMENTS + 1;
    localparam int WIPER_W      = 6;
    localparam int NV_REGS      = 4;
    localparam int PTR_W        = 2;
    localparam int OP_W         = 4;

    // Identification byte. The type code value is arbitrary.
    localparam logic [3:0] ID_TYPE_CODE = 4'h3;
    localparam logic [2:0] ID_FIXED     = 3'h6;

    // Instruction codes in the upper four bits of the second byte.
    localparam logic [OP_W-1:0] OP_READ_STATUS   = 4'h5;
    localparam logic [OP_W-1:0] OP_READ_WIPER    = 4'h9;
    localparam logic [OP_W-1:0] OP_WRITE_WIPER   = 4'ha;
    localparam logic [OP_W-1:0] OP_READ_STORED   = 4'hb;
    localparam logic [OP_W-1:0] OP_WRITE_STORED  = 4'hc;
    localparam logic [OP_W-1:0] OP_XFR_TO_WIPER  = 4'hd;
    localparam logic [OP_W-1:0] OP_XFR_TO_STORED = 4'he;

    // Field positions inside the second byte and the status reply.
    localparam int INSTR_OP_LSB    = 4;
    localparam int INSTR_PTR_LSB   = 2;
    localparam int STATUS_BUSY_BIT = 0;

    // Power-up content of the nonvolatile stored settings.
    localparam logic [WIPER_W-1:0] NV_RESET_VALUE = 6'h20;

    // Nonvolatile write time.
    localparam int NV_WRITE_TIME_US    = 10000;
    localparam int CLOCK_MHZ           = 125;
    localparam int NV_WRITE_CYCLES_DEF = NV_WRITE_TIME_US * CLOCK_MHZ;

    // Layout of the state snapshot handed to the serial clock domain.
    localparam int MIR_WIPER_LSB  = 0;
    localparam int MIR_STORED_LSB = WIPER_W;
    localparam int MIR_BUSY       = MIR_STORED_LSB + NV_REGS * WIPER_W;
    localparam int MIR_ARMED      = MIR_BUSY + 1;
    localparam int MIR_W          = MIR_ARMED + 1;

    typedef enum logic [3:0] {
        LK_ID    = 4'h1,
        LK_INSTR = 4'h2,
        LK_DATA  = 4'h4,
        LK_SKIP  = 4'h8
    } spp_link_state_t;

endpackage : spp_pkg

// ==== hdl/spp_sync.sv ====
// Two flip-flop level synchroniser with synchronous reset.
`timescale 1ns/10ps
module spp_sync
    import spp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : spp_sync

// ==== hdl/spp_pot_interface.sv ====
// Serial slave front end and register set of a 64-tap digital potentiometer.
`timescale 1ns/10ps
module spp_pot_interface
    import spp_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                sck,
    input  wire logic                cs_n,
    input  wire logic                si,
    input  wire logic                hold_n,
    input  wire logic                wp_n,
    input  wire logic                address_strap_bit,
    output logic                     so,
    output logic                     so_oe,
    output logic [WIPER_W-1:0]       wiper_position_register,
    output logic [SPP_TAPS-1:0]      tap_select,
    output logic                     standby,
    output logic                     nv_write_busy_flag
);

    localparam int CW = $clog2(NV_WRITE_CYCLES + 1);

    function automatic logic is_xfr(input logic [OP_W-1:0] op);
        return (op == OP_XFR_TO_WIPER) || (op == OP_XFR_TO_STORED);
    endfunction : is_xfr

    function automatic logic is_write(input logic [OP_W-1:0] op);
        return (op == OP_WRITE_WIPER) || (op == OP_WRITE_STORED);
    endfunction : is_write

    function automatic logic is_read(input logic [OP_W-1:0] op);
        return (op == OP_READ_WIPER) || (op == OP_READ_STORED) || (op == OP_READ_STATUS);
    endfunction : is_read

    function automatic logic [7:0] reply_byte(input logic [OP_W-1:0]  op,
                                              input logic [PTR_W-1:0] ptr,
                                              input logic [MIR_W-1:0] mir);
        logic [7:0] r;
        r = 8'h00;
        if (op == OP_READ_WIPER) begin
            r = {2'h0, mir[MIR_WIPER_LSB +: WIPER_W]};
        end else if (op == OP_READ_STORED) begin
            r = {2'h0, mir[MIR_STORED_LSB + WIPER_W * ptr +: WIPER_W]};
        end else if (op == OP_READ_STATUS) begin
            r[STATUS_BUSY_BIT] = mir[MIR_BUSY];
        end
        return r;
    endfunction : reply_byte

    function automatic logic [SPP_TAPS-1:0] tap_decode(input logic [WIPER_W-1:0] pos);
        logic [SPP_TAPS-1:0] t;
        t      = '0;
        t[pos] = 1'b1;
        return t;
    endfunction : tap_decode

    // System clock domain.
    logic                      cs_s;
    logic                      wp_s;
    logic                      done_s;
    logic                      cs_q;
    logic                      done_q;
    logic                      done_rise;
    logic                      armed;
    logic                      recall;
    logic [WIPER_W-1:0]        stored [NV_REGS];
    logic                      pend;
    logic [PTR_W-1:0]          pend_ptr;
    logic [WIPER_W-1:0]        pend_data;
    logic                      commit;
    logic                      busy;
    logic [CW-1:0]             nv_count;
    logic [MIR_W-1:0]          mirror;

    // Link domain.
    logic                      strap_l;
    logic [MIR_W-1:0]          mir_l;
    spp_link_state_t           state;
    logic [2:0]                bit_idx;
    logic [7:0]                shreg;
    logic [7:0]                next_byte;
    logic                      byte_end;
    logic                      id_ok;
    logic                      link_done;
    logic [OP_W-1:0]           cmd_op;
    logic [PTR_W-1:0]          cmd_ptr;
    logic [WIPER_W-1:0]        cmd_data;
    logic                      rd_phase;
    logic                      so_en;
    logic [7:0]                reply;

    spp_sync #(
        .WIDTH (3)
    ) u_sys_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({link_done, wp_n, cs_n}),
        .q     ({done_s, wp_s, cs_s})
    );

    // Snapshot values other than the busy bit change only between frames, so those bits settle long before they are used.
    spp_sync #(
        .WIDTH (MIR_W + 1)
    ) u_link_sync (
        .clock (sck),
        .rst   (1'b0),
        .d     ({address_strap_bit, mirror}),
        .q     ({strap_l, mir_l})
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            cs_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cs_q   <= cs_s;
            done_q <= done_s;
        end
    end

    assign done_rise = done_s & ~done_q;

    // The sampled select resets low, so a select already low at release does not count.
    always_ff @(posedge clock) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (cs_q && !cs_s) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            recall <= 1'b1;
        end else begin
            recall <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wiper_position_register <= NV_RESET_VALUE;
        end else if (recall) begin
            wiper_position_register <= stored[0];
        end else if (done_rise && cmd_op == OP_WRITE_WIPER) begin
            wiper_position_register <= cmd_data;
        end else if (done_rise && cmd_op == OP_XFR_TO_WIPER) begin
            wiper_position_register <= stored[cmd_ptr];
        end
    end

    // A stored write waits for select to rise; a request while one is running is dropped.
    always_ff @(posedge clock) begin
        if (rst) begin
            pend      <= 1'b0;
            pend_ptr  <= '0;
            pend_data <= '0;
        end else if (done_rise && wp_s && !busy && !pend &&
                     (cmd_op == OP_WRITE_STORED || cmd_op == OP_XFR_TO_STORED)) begin
            pend      <= 1'b1;
            pend_ptr  <= cmd_ptr;
            pend_data <= (cmd_op == OP_WRITE_STORED) ? cmd_data : wiper_position_register;
        end else if (commit) begin
            pend <= 1'b0;
        end
    end

    assign commit = pend & cs_s;

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NV_REGS; i++) begin
                stored[i] <= NV_RESET_VALUE;
            end
        end else if (commit) begin
            stored[pend_ptr] <= pend_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy     <= 1'b0;
            nv_count <= '0;
        end else if (commit) begin
            busy     <= 1'b1;
            nv_count <= CW'(NV_WRITE_CYCLES - 1);
        end else if (busy) begin
            if (nv_count == '0) begin
                busy <= 1'b0;
            end else begin
                nv_count <= nv_count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            nv_write_busy_flag <= 1'b0;
            standby            <= 1'b0;
        end else begin
            nv_write_busy_flag <= busy | pend;
            standby            <= cs_s & ~busy & ~pend;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mirror <= '0;
        end else begin
            mirror[MIR_WIPER_LSB +: WIPER_W] <= wiper_position_register;
            for (int i = 0; i < NV_REGS; i++) begin
                mirror[MIR_STORED_LSB + WIPER_W * i +: WIPER_W] <= stored[i];
            end
            mirror[MIR_BUSY]  <= busy | pend;
            mirror[MIR_ARMED] <= armed;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tap_select <= '0;
        end else begin
            tap_select <= tap_decode(wiper_position_register);
        end
    end

    // Link side. The host moves the pause input only while the serial clock is low,
    // so it is stable at every edge and is used here without a synchroniser.
    assign next_byte = {shreg[6:0], si};
    assign byte_end  = hold_n && (bit_idx == 3'h7);
    assign id_ok     = mir_l[MIR_ARMED] &&
                       next_byte[7:4] == ID_TYPE_CODE &&
                       next_byte[3:1] == ID_FIXED &&
                       next_byte[0] == strap_l;
    assign rd_phase  = (state == LK_DATA) && is_read(cmd_op);
    assign reply     = reply_byte(cmd_op, cmd_ptr, mir_l);

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            shreg   <= '0;
            bit_idx <= '0;
        end else if (hold_n) begin
            shreg   <= next_byte;
            bit_idx <= bit_idx + 3'h1;
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            state <= LK_ID;
        end else if (byte_end) begin
            unique case (state)
                LK_ID: begin
                    state <= id_ok ? LK_INSTR : LK_SKIP;
                end
                LK_INSTR: begin
                    if (!is_xfr(next_byte[7:4]) &&
                        (is_read(next_byte[7:4]) || is_write(next_byte[7:4]))) begin
                        state <= LK_DATA;
                    end else begin
                        state <= LK_SKIP;
                    end
                end
                LK_DATA: begin
                    state <= LK_SKIP;
                end
                LK_SKIP: begin
                    state <= LK_SKIP;
                end
                default: begin
                    state <= LK_SKIP;
                end
            endcase
        end
    end

    // Command words carry no reset; the system side reads them only while the done level stands.
    always_ff @(posedge sck) begin
        if (byte_end && state == LK_INSTR) begin
            cmd_op  <= next_byte[INSTR_OP_LSB +: OP_W];
            cmd_ptr <= next_byte[INSTR_PTR_LSB +: PTR_W];
        end
        if (byte_end && state == LK_DATA) begin
            cmd_data <= next_byte[WIPER_W-1:0];
        end
    end

    // The done level is cleared by select itself, since the serial clock may stop.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            link_done <= 1'b0;
        end else if (byte_end && state == LK_INSTR && is_xfr(next_byte[7:4])) begin
            link_done <= 1'b1;
        end else if (byte_end && state == LK_DATA && is_write(cmd_op)) begin
            link_done <= 1'b1;
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so    <= 1'b0;
            so_en <= 1'b0;
        end else if (hold_n) begin
            so_en <= rd_phase;
            so    <= reply[3'h7 - bit_idx];
        end
    end

    // Output floats during a pause so a shared data line is released.
    assign so_oe = so_en & hold_n;

endmodule : spp_pot_interface

// ==== verif/spp_pot_props.sv ====
// Port assertions of the potentiometer serial front end, bound to its top module.
`timescale 1ns/10ps
module spp_pot_props
    import spp_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic                sck,
    input wire logic                cs_n,
    input wire logic                hold_n,
    input wire logic                so,
    input wire logic                so_oe,
    input wire logic [WIPER_W-1:0]  wiper_position_register,
    input wire logic [SPP_TAPS-1:0] tap_select,
    input wire logic                standby,
    input wire logic                nv_write_busy_flag
);
    // Select high clears the edge count just as it clears the link logic.
    logic [4:0]  edges;
    int unsigned busy_len;
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            edges <= 5'h00;
        end else if (hold_n) begin
            edges <= edges + 5'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (rst || !nv_write_busy_flag) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end
    sequence s_selected;
        !cs_n [*4];
    endsequence
    sequence s_busy_end;
        $fell(nv_write_busy_flag);
    endsequence
    a_tap_one_hot: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> tap_select == (64'h1 << $past(wiper_position_register)))
        else $error("tap select does not follow wiper");
    a_select_wakes: assert property (@(posedge clock) disable iff (rst)
        s_selected |-> !standby) else $error("standby while selected");
    a_busy_awake: assert property (@(posedge clock) disable iff (rst)
        nv_write_busy_flag && $past(nv_write_busy_flag) |-> !standby)
        else $error("standby during stored write");
    a_busy_long: assert property (@(posedge clock) disable iff (rst)
        s_busy_end |-> busy_len >= NV_WRITE_CYCLES) else $error("stored write too short");
    a_busy_bounded: assert property (@(posedge clock) disable iff (rst)
        busy_len <= NV_WRITE_CYCLES + 64) else $error("stored write too long");
    a_float_deselect: assert property (@(posedge clock) disable iff (rst)
        cs_n |-> !so_oe) else $error("output driven while deselected");
    a_float_paused: assert property (@(posedge clock) disable iff (rst)
        !hold_n |-> !so_oe) else $error("output driven while paused");
    a_so_falling: assert property (@(posedge clock) disable iff (rst)
        $changed(so) |-> !sck) else $error("output moved off a falling edge");
    a_read_window: assert property (@(negedge sck) disable iff (cs_n)
        so_oe |-> edges inside {[5'd17:5'd24]}) else $error("output driven off reply");
    a_idle_frozen: assert property (@(posedge clock) disable iff (rst)
        standby |=> $stable(wiper_position_register)) else $error("wiper moved idle");
endmodule : spp_pot_props
bind spp_pot_interface spp_pot_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) spp_pot_props_inst (
    .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .so(so),
    .so_oe(so_oe), .wiper_position_register(wiper_position_register),
    .tap_select(tap_select), .standby(standby), .nv_write_busy_flag(nv_write_busy_flag)
);

// ==== verif/spp_host_model.sv ====
// Behavioural host controller that drives the serial lines of the potentiometer.
`timescale 1ns/10ps
module spp_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so,
    input  wire logic so_oe
);
    // Select falls while the device is still in reset, so no fall is seen after it.
    initial begin
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        // Select rises only once every process waits, so the link logic surely starts cleared.
        cs_n = 1'b0;
        #4;
        cs_n = 1'b1;
        #16;
        cs_n = 1'b0;
    end
    // A floating reply bit is kept as z, so an undriven output never passes for data.
    task automatic frame(input logic [23:0] bits, input int nbits, input int hold_at,
                         output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        #153.3;
        for (int i = 0; i < nbits; i++) begin
            if (i == hold_at) begin
                #12;
                hold_n = 1'b0;
                si = ~si;
                repeat (2) begin
                    #24 sck = 1'b1;
                    #24 sck = 1'b0;
                end
                #12;
                hold_n = 1'b1;
            end
            si = bits[23-i];
            #24 sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'bz};
            #24 sck = 1'b0;
        end
        #48 cs_n = 1'b1;
        si = ~si;
        #80;
    endtask : frame
endmodule : spp_host_model

// ==== verif/spp_pot_interface_test.sv ====
// Self-checking bench of the potentiometer front end driven by a behavioural host.
`timescale 1ns/10ps
module spp_pot_interface_test;
    import spp_pkg::*;
    // Short enough for a brief run, long enough to outlast one status read.
    localparam int NV_CYC = 200;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic                wp_n = 1'b1;
    logic                strap = 1'b0;
    logic                sck, cs_n, si, hold_n, so, so_oe, standby, busy;
    logic [WIPER_W-1:0]  wiper;
    logic [SPP_TAPS-1:0] taps;
    logic [7:0]          rx;
    int                  fails = 0;
    int                  n_compared = 0;
    always #4 clock = ~clock;
    spp_pot_interface #(.NV_WRITE_CYCLES(NV_CYC)) spp_pot_interface_inst (
        .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .address_strap_bit(strap), .so(so), .so_oe(so_oe),
        .wiper_position_register(wiper), .tap_select(taps), .standby(standby),
        .nv_write_busy_flag(busy));
    spp_host_model spp_host_model_inst (
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
    function automatic logic [23:0] cmd(logic a, logic [3:0] op, logic [1:0] p, logic [5:0] d);
        return {ID_TYPE_CODE, ID_FIXED, a, op, p, 2'b00, 2'b00, d};
    endfunction : cmd
    task automatic send(input logic [23:0] bits, input int nbits, input int hold_at = 99);
        spp_host_model_inst.frame(bits, nbits, hold_at, rx);
    endtask : send
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_idle;
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge clock);
        chk("busy", 1'b0, busy);
    endtask : wait_idle
    task automatic t_power_up;
        chk("wiper", NV_RESET_VALUE, wiper);
        chk("taps", 64'h1 << NV_RESET_VALUE, taps);
        send(cmd(1'b0, OP_WRITE_WIPER, 2'h0, 6'h15), 24);
        chk("wiper", NV_RESET_VALUE, wiper);
        chk("standby", 1'b1, standby);
    endtask : t_power_up
    task automatic t_wiper(input logic [5:0] d, input int h);
        send(cmd(1'b0, OP_WRITE_WIPER, 2'h0, d), 24, h);
        chk("wiper", d, wiper);
        chk("taps", 64'h1 << d, taps);
        send(cmd(1'b0, OP_READ_WIPER, 2'h0, 6'h00), 24, h - 1);
        chk("wiper reply", {2'b00, d}, rx);
    endtask : t_wiper
    task automatic t_strap;
        @(posedge clock) strap <= 1'b1;
        send(cmd(1'b0, OP_WRITE_WIPER, 2'h0, 6'h07), 24);
        chk("wiper", 6'h3f, wiper);
        send(cmd(1'b0, OP_READ_WIPER, 2'h0, 6'h00), 24);
        chk("mismatch reply", 8'hzz, rx);
        for (int k = 17; k < 21; k += 3) begin
            send(cmd(1'b1, OP_WRITE_WIPER, 2'h0, 6'h07) ^ (24'h1 << k), 24);
            chk("wiper", 6'h3f, wiper);
        end
        send(cmd(1'b1, OP_WRITE_WIPER, 2'h0, 6'h07), 24);
        chk("wiper", 6'h07, wiper);
        @(posedge clock) strap <= 1'b0;
    endtask : t_strap
    task automatic t_stored;
        for (int p = 0; p < NV_REGS; p++) begin
            send(cmd(1'b0, OP_WRITE_STORED, 2'(p), 6'h10 + 6'(p)), 24);
            chk("standby", 1'b0, standby);
            send(cmd(1'b0, OP_READ_STATUS, 2'h0, 6'h00), 24);
            chk("status", 8'h01 << STATUS_BUSY_BIT, rx);
            wait_idle();
            send(cmd(1'b0, OP_READ_STATUS, 2'h0, 6'h00), 24);
            chk("status", 8'h00, rx);
            send(cmd(1'b0, OP_READ_STORED, 2'(p), 6'h00), 24);
            chk("stored", 8'h10 + 8'(p), rx);
        end
    endtask : t_stored
    task automatic t_protect;
        @(posedge clock) wp_n <= 1'b0;
        send(cmd(1'b0, OP_WRITE_STORED, 2'h1, 6'h3e), 24);
        send(cmd(1'b0, OP_WRITE_WIPER, 2'h0, 6'h3e), 24);
        chk("wiper", 6'h3e, wiper);
        send(cmd(1'b0, OP_READ_STORED, 2'h1, 6'h00), 24);
        chk("protected", 8'h11, rx);
        @(posedge clock) wp_n <= 1'b1;
        send(cmd(1'b0, OP_XFR_TO_WIPER, 2'h2, 6'h00), 16);
        chk("wiper", 6'h12, wiper);
        send(cmd(1'b0, OP_XFR_TO_STORED, 2'h3, 6'h00), 16);
        wait_idle();
        send(cmd(1'b0, OP_READ_STORED, 2'h3, 6'h00), 24);
        chk("copied", 8'h12, rx);
    endtask : t_protect
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_power_up();
        t_wiper(6'h15, 99);
        t_wiper(6'h2a, 20);
        t_wiper(6'h00, 9);
        t_wiper(6'h3f, 99);
        t_strap();
        t_stored();
        t_protect();
        tally_and_finish();
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule : spp_pot_interface_test
